/* testbench/dram_cycle_sequencer_tb.sv */
// Testbench for the cycle sequencer: runs each cycle kind, judges length and strobes.
// Assumes package, design, far-side model and checker are compiled first.
`default_nettype none
module dram_cycle_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, nrst_in = 1'b0, start_in = 1'b0, port_b_in = 1'b0, port_a_fast_in = 1'b1;
  logic slow_cycle_in = 1'b0, slow_ram_in = 1'b0, extend_in = 1'b0, freq_in = 1'b0, command_in = 1'b0;
  logic err_en = 1'b0, fatal_en = 1'b0, s_we, s_ack, s_error_strobe, s_lat, s_dm, lat0;
  wire dm;
  logic [2:0] kind_in = 3'h0;
  wire error_in, fatal_in, busy_out, row_n, col_n, we_n, lat, error_strobe, eack_n, lack_n, transfer_ack_n;
  int err_count = 0, n_compared = 0, len;
  dram_cycle_sequencer dram_cycle_sequencer_i (.clk_in(clk_in), .nrst_in(nrst_in), .start_in(start_in),
    .kind_in(kind_in), .port_b_in(port_b_in), .port_a_fast_in(port_a_fast_in), .slow_cycle_in(slow_cycle_in),
    .slow_ram_in(slow_ram_in), .extend_in(extend_in), .freq_in(freq_in), .error_in(error_in),
    .fatal_in(fatal_in), .command_in(command_in), .busy_out(busy_out), .row_strobe_n_out(row_n),
    .col_strobe_n_out(col_n), .write_strobe_n_out(we_n), .read_write_out(), .port_switch_strobe_out(),
    .port_select_out(), .correction_data_mode_out(dm), .address_latch_strobe_out(lat),
    .address_mux_select_out(), .error_strobe_out(error_strobe), .early_ack_n_out(eack_n),
    .late_ack_n_out(lack_n), .transfer_ack_n_out(transfer_ack_n));
  dram_ecc_model dram_ecc_model_i (.clk_in(clk_in), .nrst_in(nrst_in), .row_strobe_n_in(row_n),
    .err_en_in(err_en), .fatal_en_in(fatal_en), .error_out(error_in), .fatal_out(fatal_in));
  // 200 MHz controller clock
  always #2.5 clk_in = ~clk_in;
  // Gather what each strobe did while a cycle runs
  always @(posedge clk_in) begin
    if (busy_out === 1'b1) begin
      if (we_n !== 1'b1) s_we <= 1'b1;
      if (eack_n !== 1'b1 || lack_n !== 1'b1 || transfer_ack_n !== 1'b1) s_ack <= 1'b1;
      if (error_strobe !== 1'b0) s_error_strobe <= 1'b1;
      if (lat !== lat0) s_lat <= 1'b1;
      if (dm !== 1'b0) s_dm <= 1'b1;
    end
  end
  task automatic close_out;
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One whole cycle; drop > 0 releases the command at that busy clock
  task automatic run(input logic [2:0] k, input logic sc, sr, ex, e, f, pb, input int drop);
    @(posedge clk_in);
    kind_in <= k;
    slow_cycle_in <= sc;
    slow_ram_in <= sr;
    extend_in <= ex;
    err_en <= e;
    fatal_en <= f;
    port_b_in <= pb;
    start_in <= 1'b1;
    // Refresh has no requesting command behind it
    command_in <= (k != 3'(cycle_seq_pkg::KIND_REFRESH));
    {s_we, s_ack, s_error_strobe, s_lat, s_dm} = 5'h00;
    lat0 = lat;
    @(posedge clk_in);
    start_in <= 1'b0;
    #1;
    len = 0;
    while (busy_out === 1'b1 && len < 40) begin
      @(posedge clk_in);
      if (len + 1 == drop) command_in <= 1'b0;
      #1;
      if (len + 2 == drop) chk(transfer_ack_n, 1'b0);
      if (len + 1 == drop) chk(transfer_ack_n, 1'b1);
      len++;
    end
    // Command goes inactive once the cycle is over
    @(posedge clk_in);
    command_in <= 1'b0;
    if (len >= 40) begin
      err_count++;
      close_out();
    end
  endtask : run
  // Fast full writes in the quick and the slow-RAM configuration
  task automatic t_write;
    run(cycle_seq_pkg::KIND_WRITE, 0, 0, 0, 0, 0, 0, 0);
    chk(len[7:0], 8'h08);
    chk(s_we, 1'b1);
    chk(s_lat, 1'b1);
    run(cycle_seq_pkg::KIND_WRITE, 0, 1, 1, 0, 0, 0, 0);
    chk(len[7:0], 8'h09);
  endtask : t_write
  // Partial writes, clean then with an uncorrectable error
  task automatic t_partial;
    run(cycle_seq_pkg::KIND_PARTIAL, 0, 0, 0, 0, 0, 0, 0);
    chk(len[7:0], 8'h0c);
    chk(s_we, 1'b1);
    chk(s_error_strobe, 1'b0);
    chk(s_dm, 1'b0);
    run(cycle_seq_pkg::KIND_PARTIAL, 0, 1, 1, 1, 1, 0, 0);
    chk(len[7:0], 8'h0e);
    chk(s_we, 1'b0);
    chk(s_dm, 1'b0);
  endtask : t_partial
  // Reads: fatal error keeps plain acks and writes nothing; command drop frees ack
  task automatic t_read;
    run(cycle_seq_pkg::KIND_READ, 0, 0, 0, 1, 1, 0, 0);
    chk(s_we, 1'b0);
    chk(s_ack, 1'b1);
    run(cycle_seq_pkg::KIND_READ, 1, 0, 0, 0, 0, 0, 0);
    chk(len[7:0], 8'h05);
    run(cycle_seq_pkg::KIND_READ, 0, 0, 0, 0, 0, 0, 8);
  endtask : t_read
  // Refresh on either port select, then with correctable and fatal errors
  task automatic t_refresh;
    for (int pb = 0; pb < 2; pb++) begin
      run(cycle_seq_pkg::KIND_REFRESH, 1, 0, 0, 0, 0, pb[0], 0);
      chk(len[7:0], 8'h05);
      chk({s_ack, s_error_strobe, s_lat}, 3'h0);
    end
    run(cycle_seq_pkg::KIND_REFRESH, 0, 0, 0, 1, 0, 0, 0);
    chk({s_we, s_ack, s_error_strobe}, 3'h4);
    run(cycle_seq_pkg::KIND_REFRESH, 0, 0, 0, 1, 1, 0, 0);
    chk({s_we, s_ack, s_error_strobe}, 3'h0);
    run(cycle_seq_pkg::KIND_INIT, 0, 0, 0, 0, 0, 0, 0);
    chk(s_we, 1'b1);
  endtask : t_refresh
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_write();
    t_partial();
    t_read();
    t_refresh();
    close_out();
  end
endmodule : dram_cycle_sequencer_tb
`default_nettype wire

/* testbench/dram_ecc_model.sv */
// Far-side model: error correction unit reporting check results.
// Assumes the bench sets the error and fatal flags before each cycle starts.
`default_nettype none
module dram_ecc_model (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic row_strobe_n_in,
  input  wire logic err_en_in,
  input  wire logic fatal_en_in,
  output logic      error_out,
  output logic      fatal_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic toggle_r;
  // Check lines are only meaningful in a row cycle; between cycles they wander
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) toggle_r <= 1'b0;
    else toggle_r <= ~toggle_r;
  end
  assign error_out = row_strobe_n_in ? toggle_r : err_en_in;
  assign fatal_out = row_strobe_n_in ? ~toggle_r : (err_en_in & fatal_en_in);
endmodule : dram_ecc_model
`default_nettype wire

/* testbench/seq_checker_props.sv */
// Checker for the cycle sequencer: strobe order, cycle lengths, quiet refresh.
// Assumes it is bound to the sequencer top and sees only its ports.
`default_nettype none
module seq_checker (
  input wire logic       clk_in, nrst_in, start_in, slow_cycle_in, slow_ram_in, extend_in, command_in,
  input wire logic [2:0] kind_in,
  input wire logic       busy_out, row_strobe_n_out, col_strobe_n_out, write_strobe_n_out,
  input wire logic       address_latch_strobe_out, early_ack_n_out, late_ack_n_out, transfer_ack_n_out
);
  // ****************************************************************
  // Cycle attributes held from the accepted start; inputs may move on
  // ****************************************************************
  logic [2:0] kind_r, kind_nxt;
  logic       slow_r, slow_nxt, sx_r, sx_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic       take;
  assign take = start_in && !busy_out;
  // Count busy clocks so cycle lengths can be judged at the end
  always_comb begin
    kind_nxt = take ? kind_in : kind_r;
    slow_nxt = take ? slow_cycle_in : slow_r;
    sx_nxt   = take ? (slow_ram_in & extend_in) : sx_r;
    cnt_nxt  = take ? 5'h00 : cnt_r + {4'h0, busy_out};
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      kind_r <= 3'h0;
      slow_r <= 1'b0;
      sx_r   <= 1'b0;
      cnt_r  <= 5'h00;
    end else begin
      kind_r <= kind_nxt;
      slow_r <= slow_nxt;
      sx_r   <= sx_nxt;
      cnt_r  <= cnt_nxt;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_row_answer: assert property (take |=> !row_strobe_n_out)
    else $error("row strobe late after start");
  a_cas_in_row: assert property ($fell(col_strobe_n_out) |-> !row_strobe_n_out)
    else $error("column strobe without row strobe");
  a_transfer_ack_release: assert property (!command_in |-> transfer_ack_n_out)
    else $error("transfer ack held without command");
  a_we_after_cas: assert property ($fell(write_strobe_n_out) && kind_r != cycle_seq_pkg::KIND_INIT
    |-> !col_strobe_n_out) else $error("write strobe before column strobe");
  a_init_we_lead: assert property ($fell(col_strobe_n_out) && kind_r == cycle_seq_pkg::KIND_INIT
    |-> !write_strobe_n_out && !$past(write_strobe_n_out, 2)) else $error("init write lead too short");
  a_refresh_no_ack: assert property (take && kind_in == cycle_seq_pkg::KIND_REFRESH
    |=> (early_ack_n_out && late_ack_n_out && transfer_ack_n_out)[*8]) else $error("ack during refresh");
  a_refresh_no_latch: assert property (take && kind_in == cycle_seq_pkg::KIND_REFRESH
    |=> $stable(address_latch_strobe_out)[*5]) else $error("latch strobe in refresh");
  a_write_len: assert property ($fell(busy_out) && kind_r == cycle_seq_pkg::KIND_WRITE && !slow_r
    |-> cnt_r == (sx_r ? 5'h09 : 5'h08)) else $error("fast write length wrong");
  a_rmw_len: assert property ($fell(busy_out) && kind_r == cycle_seq_pkg::KIND_PARTIAL && !slow_r
    |-> cnt_r == (sx_r ? 5'h0e : 5'h0c)) else $error("modify-write length wrong");
endmodule : seq_checker
bind dram_cycle_sequencer seq_checker seq_checker_i (.clk_in(clk_in), .nrst_in(nrst_in), .start_in(start_in),
  .slow_cycle_in(slow_cycle_in), .slow_ram_in(slow_ram_in), .extend_in(extend_in), .command_in(command_in),
  .kind_in(kind_in), .busy_out(busy_out), .row_strobe_n_out(row_strobe_n_out),
  .col_strobe_n_out(col_strobe_n_out), .write_strobe_n_out(write_strobe_n_out),
  .address_latch_strobe_out(address_latch_strobe_out), .early_ack_n_out(early_ack_n_out),
  .late_ack_n_out(late_ack_n_out), .transfer_ack_n_out(transfer_ack_n_out));
`default_nettype wire

/* verilog/cycle_seq_pkg.sv */
// Constants for the DRAM cycle sequencer: cycle kinds, configurations,
// and the per-configuration strobe edge schedule (half-clock units).
// Assumes a single 200 MHz controller clock; edges are counted from clock 0.
`default_nettype none

package cycle_seq_pkg;

  // ****************************************************************
  // Cycle kinds
  // ****************************************************************
  typedef enum logic [2:0] {
    KIND_READ    = 3'h0,
    KIND_WRITE   = 3'h1,
    KIND_PARTIAL = 3'h2,
    KIND_REFRESH = 3'h3,
    KIND_INIT    = 3'h4
  } kind_t;

  typedef enum logic [1:0] {
    ROW_RD  = 2'h0,
    ROW_WR  = 2'h1,
    ROW_RMW = 2'h2
  } row_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_RUN  = 1'h1
  } state_t;

  // Edge positions are half clocks: 2n is n falling, 2n+1 is n rising
  localparam int EW = 5;
  typedef logic [EW-1:0] edge_t;

  typedef struct packed {
    edge_t sw_l;   // Port switch strobe low
    edge_t dm_h;   // Correction data mode low
    edge_t ras_h;  // Row strobe high
    edge_t cas_l;  // Column strobe low
    edge_t cas_h;  // Column strobe high
    edge_t we_l;   // Write strobe low
    edge_t we_h;   // Write strobe high
    edge_t rw_l;   // Correction read/write low
    edge_t len_h;  // Address latch low
    edge_t end_e;  // Cycle end
  } sched_t;

  localparam edge_t E_NONE = 5'h1f;
  localparam logic [2:0] NUM_CFG = 3'h7;

  // Config index packs slow-cycle flag and the ram/extend/frequency bits
  localparam logic [2:0] CFG_C0 = 3'h0;
  localparam logic [2:0] CFG_C1 = 3'h1;
  localparam logic [2:0] CFG_C2 = 3'h2;
  localparam logic [2:0] CFG_C3 = 3'h3;
  localparam logic [2:0] CFG_C4 = 3'h4;
  localparam logic [2:0] CFG_C5 = 3'h5;
  localparam logic [2:0] CFG_C6 = 3'h6;

  // Initialization write strobe lead in half clocks before column strobe
  localparam edge_t INIT_WE_L = 5'h02;
  localparam edge_t INIT_CAS_L = 5'h08;

  // Correcting-mode schedules, row then config; falling edges as 2n
  function automatic sched_t sched(input row_t row, input logic [2:0] cfg);
    sched_t s;
    logic   fast01;
    logic   slow;
    s      = '{default: E_NONE};
    fast01 = (cfg == CFG_C0) || (cfg == CFG_C1);
    slow   = (cfg >= CFG_C4);
    s.len_h = slow ? E_NONE : 5'h04;
    if (!slow) begin
      case (row)
        ROW_RD: begin
          s = '{sw_l: fast01 ? 5'h0a : 5'h0c, dm_h: fast01 ? 5'h0c : 5'h0e,
                ras_h: fast01 ? 5'h08 : 5'h0a, cas_l: 5'h02, cas_h: fast01 ? 5'h0c : 5'h0e,
                we_l: E_NONE, we_h: E_NONE, rw_l: E_NONE, len_h: 5'h04,
                end_e: fast01 ? 5'h10 : 5'h12};
        end
        ROW_WR: begin
          s = '{sw_l: fast01 ? 5'h0a : 5'h0c, dm_h: E_NONE,
                ras_h: fast01 ? 5'h0c : 5'h0e, cas_l: 5'h02, cas_h: fast01 ? 5'h0c : 5'h0e,
                we_l: fast01 ? 5'h06 : 5'h08, we_h: fast01 ? 5'h0c : 5'h0e,
                rw_l: 5'h02, len_h: 5'h04, end_e: fast01 ? 5'h10 : 5'h12};
        end
        default: begin
          s = '{sw_l: fast01 ? 5'h10 : 5'h14, dm_h: fast01 ? 5'h12 : 5'h16,
                ras_h: fast01 ? 5'h12 : 5'h16, cas_l: 5'h02, cas_h: fast01 ? 5'h12 : 5'h16,
                we_l: fast01 ? 5'h0c : 5'h10, we_h: fast01 ? 5'h12 : 5'h16,
                rw_l: fast01 ? 5'h08 : 5'h0a, len_h: 5'h04, end_e: fast01 ? 5'h18 : 5'h1c};
        end
      endcase
    end else begin
      case (row)
        ROW_RD: begin
          s = '{sw_l: 5'h06, dm_h: 5'h08, ras_h: 5'h06, cas_l: 5'h00, cas_h: 5'h08,
                we_l: E_NONE, we_h: E_NONE, rw_l: E_NONE, len_h: E_NONE, end_e: 5'h0a};
        end
        ROW_WR: begin
          s = '{sw_l: (cfg == CFG_C6) ? 5'h06 : 5'h08, dm_h: E_NONE,
                ras_h: (cfg == CFG_C6) ? 5'h08 : 5'h0a, cas_l: 5'h00,
                cas_h: (cfg == CFG_C6) ? 5'h08 : 5'h0a, we_l: (cfg == CFG_C6) ? 5'h05 : 5'h07,
                we_h: (cfg == CFG_C6) ? 5'h08 : 5'h0a, rw_l: 5'h03, len_h: E_NONE,
                end_e: (cfg == CFG_C6) ? 5'h0a : 5'h0c};
        end
        default: begin
          s = '{sw_l: (cfg == CFG_C6) ? 5'h08 : 5'h0c, dm_h: (cfg == CFG_C6) ? 5'h0a : 5'h0e,
                ras_h: (cfg == CFG_C6) ? 5'h0a : 5'h0e, cas_l: 5'h00,
                cas_h: (cfg == CFG_C6) ? 5'h0a : 5'h0e, we_l: (cfg == CFG_C6) ? 5'h07 : 5'h0b,
                we_h: (cfg == CFG_C6) ? 5'h0a : 5'h0e, rw_l: (cfg == CFG_C6) ? 5'h05 : 5'h07,
                len_h: E_NONE, end_e: (cfg == CFG_C6) ? 5'h0c : 5'h10};
        end
      endcase
    end
    return s;
  endfunction : sched

endpackage : cycle_seq_pkg

`default_nettype wire

/* verilog/dram_cycle_sequencer.sv */
// DRAM cycle sequencer: issues row, column, write and port-side strobes
// for one memory cycle at a time in error-correcting mode.
// Assumes arbitration has already chosen the cycle; inputs are synchronous.
`default_nettype none

module dram_cycle_sequencer (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       start_in,
  input  wire logic [2:0] kind_in,
  input  wire logic       port_b_in,
  input  wire logic       port_a_fast_in,
  input  wire logic       slow_cycle_in,
  input  wire logic       slow_ram_in,
  input  wire logic       extend_in,
  input  wire logic       freq_in,
  input  wire logic       error_in,
  input  wire logic       fatal_in,
  input  wire logic       command_in,
  output logic            busy_out,
  output logic            row_strobe_n_out,
  output logic            col_strobe_n_out,
  output logic            write_strobe_n_out,
  output logic            read_write_out,
  output logic            port_switch_strobe_out,
  output logic            port_select_out,
  output logic            correction_data_mode_out,
  output logic            address_latch_strobe_out,
  output logic            address_mux_select_out,
  output logic            error_strobe_out,
  output logic            early_ack_n_out,
  output logic            late_ack_n_out,
  output logic            transfer_ack_n_out
);

  // ****************************************************************
  // Cycle state
  // ****************************************************************
  cycle_seq_pkg::state_t state_r, state_nxt;
  cycle_seq_pkg::edge_t  pos_r, pos_nxt;
  cycle_seq_pkg::kind_t  kind_r, kind_nxt;
  cycle_seq_pkg::sched_t sch_r, sch_nxt;
  logic [2:0]            cfg;
  logic                  port_r, port_nxt;
  logic                  err_r, err_nxt;
  logic                  fatal_r, fatal_nxt;
  logic                  transfer_ack_r, transfer_ack_nxt;
  logic                  ras_r, cas_r, we_r, rw_r, sw_r, dm_r, len_r, mux_r, est_r, eack_r, lack_r;
  logic                  ras_nxt, cas_nxt, we_nxt, rw_nxt, sw_nxt, dm_nxt, len_nxt, mux_nxt;
  logic                  est_nxt, eack_nxt, lack_nxt;
  logic                  is_rf, is_rd, use_rmw;

  // Configuration from programming bits; slow RAM and extend together lengthen (fast cycles, freq low)
  always_comb begin
    if (slow_cycle_in) begin
      cfg = (slow_ram_in && extend_in && !freq_in) ? cycle_seq_pkg::CFG_C4 :
            (freq_in ? cycle_seq_pkg::CFG_C6 : cycle_seq_pkg::CFG_C5);
    end else if (freq_in) begin
      cfg = cycle_seq_pkg::CFG_C0;
    end else begin
      cfg = (slow_ram_in && extend_in) ? cycle_seq_pkg::CFG_C3 :
            ((slow_ram_in || extend_in) ? cycle_seq_pkg::CFG_C1 : cycle_seq_pkg::CFG_C0);
    end
  end

  // Error can only change the schedule once sampled mid-cycle
  always_comb begin
    is_rf   = (kind_r == cycle_seq_pkg::KIND_REFRESH);
    is_rd   = (kind_r == cycle_seq_pkg::KIND_READ);
    use_rmw = (kind_r == cycle_seq_pkg::KIND_PARTIAL) || ((is_rd || is_rf) && err_r);
  end

  // ****************************************************************
  // Next-state and strobe edges
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    pos_nxt   = pos_r;
    kind_nxt  = kind_r;
    sch_nxt   = sch_r;
    port_nxt  = port_r;
    err_nxt   = err_r;
    fatal_nxt = fatal_r;
    ras_nxt   = ras_r;
    cas_nxt   = cas_r;
    we_nxt    = we_r;
    rw_nxt    = rw_r;
    sw_nxt    = sw_r;
    dm_nxt    = dm_r;
    len_nxt   = len_r;
    mux_nxt   = mux_r;
    est_nxt   = est_r;
    eack_nxt  = eack_r;
    lack_nxt  = lack_r;
    transfer_ack_nxt  = transfer_ack_r;
    case (state_r)
      cycle_seq_pkg::ST_IDLE: begin
        if (start_in) begin
          state_nxt = cycle_seq_pkg::ST_RUN;
          pos_nxt   = '0;
          kind_nxt  = cycle_seq_pkg::kind_t'(kind_in);
          port_nxt  = port_b_in;
          err_nxt   = 1'b0;
          fatal_nxt = 1'b0;
          ras_nxt   = 1'b1;
          sw_nxt    = 1'b1;
          // Data mode belongs to read-type rows only; writes never raise it
          dm_nxt    = (kind_in == 3'(cycle_seq_pkg::KIND_READ)) ||
                      (kind_in == 3'(cycle_seq_pkg::KIND_REFRESH));
          mux_nxt   = 1'b1;
          len_nxt   = !port_b_in && port_a_fast_in && !slow_cycle_in &&
                      (kind_in != 3'(cycle_seq_pkg::KIND_REFRESH));
          sch_nxt   = cycle_seq_pkg::sched((kind_in == 3'(cycle_seq_pkg::KIND_WRITE) ||
                                            kind_in == 3'(cycle_seq_pkg::KIND_INIT)) ?
                                           cycle_seq_pkg::ROW_WR :
                                           (kind_in == 3'(cycle_seq_pkg::KIND_PARTIAL)) ?
                                           cycle_seq_pkg::ROW_RMW : cycle_seq_pkg::ROW_RD, cfg);
          if (kind_in == 3'(cycle_seq_pkg::KIND_INIT)) begin
            sch_nxt.we_l  = cycle_seq_pkg::INIT_WE_L;
            sch_nxt.cas_l = cycle_seq_pkg::INIT_CAS_L;
          end
        end
      end
      cycle_seq_pkg::ST_RUN: begin
        pos_nxt = cycle_seq_pkg::edge_t'(pos_r + 5'h01);
        // Error arrives before the write phase; switch to modify-write row
        if (pos_r == 5'h03 && (is_rd || is_rf || kind_r == cycle_seq_pkg::KIND_PARTIAL) && error_in) begin
          err_nxt   = 1'b1;
          fatal_nxt = fatal_in;
          sch_nxt   = cycle_seq_pkg::sched(cycle_seq_pkg::ROW_RMW, cfg);
          if (is_rd) begin
            sch_nxt.cas_l = sch_r.cas_l;
          end
        end
        if (pos_r == 5'h02) begin
          mux_nxt = 1'b0;
        end
        // Table edges are half clocks; the position counts whole clocks
        if (pos_r == (sch_r.len_h >> 1)) len_nxt = 1'b0;
        if (pos_r == (sch_r.sw_l >> 1)) sw_nxt = 1'b0;
        if (pos_r == (sch_r.dm_h >> 1)) dm_nxt = 1'b0;
        if (pos_r == (sch_r.ras_h >> 1)) ras_nxt = 1'b0;
        if (pos_r == (sch_r.cas_l >> 1) && ras_r) cas_nxt = 1'b1;
        if (pos_r == (sch_r.cas_h >> 1)) cas_nxt = 1'b0;
        // Write strobe only after column strobe except initialization
        if (pos_r == (sch_r.we_l >> 1) && (cas_r || kind_r == cycle_seq_pkg::KIND_INIT) && !fatal_r) begin
          we_nxt = 1'b1;
        end
        if (pos_r == (sch_r.we_h >> 1)) we_nxt = 1'b0;
        if (pos_r == (sch_r.rw_l >> 1)) rw_nxt = 1'b1;
        if (pos_r == (sch_r.we_h >> 1)) rw_nxt = 1'b0;
        // Data mode withheld for partial writes; refresh scrubbing keeps it
        if (kind_r == cycle_seq_pkg::KIND_PARTIAL) dm_nxt = 1'b0;
        // Error strobe only for read and partial write with error
        est_nxt = err_r && !is_rf && (pos_r == (sch_r.rw_l >> 1));
        // Acks keep plain-read timing and never in refresh
        eack_nxt = !is_rf && (eack_r || pos_r == 5'h02);
        lack_nxt = !is_rf && (lack_r || pos_r == 5'h06);
        if (!is_rf && pos_r == 5'h06) transfer_ack_nxt = 1'b1;
        if (pos_r == (sch_r.end_e >> 1) - 5'h01) begin
          state_nxt = cycle_seq_pkg::ST_IDLE;
          eack_nxt  = 1'b0;
          lack_nxt  = 1'b0;
        end
      end
      default: state_nxt = cycle_seq_pkg::ST_IDLE;
    endcase
    if (!command_in) transfer_ack_nxt = 1'b0;
  end

  // Registers; each strobe set and cleared on its scheduled edge
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= cycle_seq_pkg::ST_IDLE;
      pos_r   <= '0;
      kind_r  <= cycle_seq_pkg::KIND_READ;
      sch_r   <= '{default: cycle_seq_pkg::E_NONE};
      port_r  <= 1'b0;
      err_r   <= 1'b0;
      fatal_r <= 1'b0;
      ras_r   <= 1'b0;
      cas_r   <= 1'b0;
      we_r    <= 1'b0;
      rw_r    <= 1'b0;
      sw_r    <= 1'b0;
      dm_r    <= 1'b0;
      len_r   <= 1'b0;
      mux_r   <= 1'b0;
      est_r   <= 1'b0;
      eack_r  <= 1'b0;
      lack_r  <= 1'b0;
      transfer_ack_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pos_r   <= pos_nxt;
      kind_r  <= kind_nxt;
      sch_r   <= sch_nxt;
      port_r  <= port_nxt;
      err_r   <= err_nxt;
      fatal_r <= fatal_nxt;
      ras_r   <= ras_nxt;
      cas_r   <= cas_nxt;
      we_r    <= we_nxt;
      rw_r    <= rw_nxt;
      sw_r    <= sw_nxt;
      dm_r    <= dm_nxt;
      len_r   <= len_nxt;
      mux_r   <= mux_nxt;
      est_r   <= est_nxt;
      eack_r  <= eack_nxt;
      lack_r  <= lack_nxt;
      transfer_ack_r  <= transfer_ack_nxt;
    end
  end

  // Outputs straight from flops, except transfer ack release is immediate
  always_comb begin
    busy_out                 = (state_r == cycle_seq_pkg::ST_RUN);
    row_strobe_n_out         = !ras_r;
    col_strobe_n_out         = !cas_r;
    write_strobe_n_out       = !we_r;
    read_write_out           = !rw_r;
    port_switch_strobe_out   = sw_r;
    port_select_out          = port_r;
    correction_data_mode_out = dm_r;
    address_latch_strobe_out = len_r;
    address_mux_select_out   = mux_r;
    error_strobe_out         = est_r;
    early_ack_n_out          = !eack_r;
    late_ack_n_out           = !lack_r;
    transfer_ack_n_out       = !(transfer_ack_r && command_in);
  end

endmodule : dram_cycle_sequencer

`default_nettype wire
